// ==== hdl/pcs_consts.vh ====
// Offsets, field positions, reset values and widths of the program counter core
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// Register indices; the byte address on the bus is four times the index
`define PCS_IDX_IND        8'h00
`define PCS_IDX_PCL        8'h01
`define PCS_IDX_PTR        8'h02
`define PCS_IDX_STAT       8'h03
`define PCS_IDX_LATH       8'h04
`define PCS_IDX_RCAUSE     8'h8E
`define PCS_IDX_TRIM       8'h90

// Bus geometry
`define PCS_ADR_W          10
`define PCS_IDX_LSB        2

// Reset-cause fields
`define PCS_RC_POR_BIT     1
`define PCS_RC_BOD_BIT     0
`define PCS_RC_MASK        8'h03
// Power-on flag cleared and brown-out flag set by the core reset
`define PCS_RC_RESET       2'h1

// Oscillator trim fields
`define PCS_TRIM_MSB       7
`define PCS_TRIM_LSB       2
`define PCS_TRIM_RESET     6'h20
`define PCS_TRIM_MAX       6'h3F
`define PCS_TRIM_CENTRE    6'h20
`define PCS_TRIM_MIN       6'h00

// Status field carrying the indirect bank bit
`define PCS_STAT_BANK_BIT  7
`define PCS_BANK_RESET     1'h0
`define PCS_PTR_RESET      8'h00

// Program counter and return stack
`define PCS_PC_W           13
`define PCS_LATH_W         5
`define PCS_LATH_RESET     5'h00
`define PCS_STK_DEPTH      8
`define PCS_SP_W           3
`define PCS_IRQ_VECTOR     13'h0004

// Data memory behind the pointer
`define PCS_DADR_W         9
`define PCS_DMEM_DEPTH     512

`endif

// ==== hdl/pcs_core.v ====
// Program counter, return stack, indirect addressing and reset-cause/trim registers
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_consts.vh"
// Operation
// - A power-on reset clears the power-on flag, bit 1; software sets it back.
// - A brown-out clears the brown-out flag, bit 0; software sets it back.
// - Trim field is bits 7..2; all ones fastest, 100000 centre, zeros slowest.
// - Trim bits 1..0 and reset-cause bits 7..2 always read zero.
// - The counter is 13 bits; its low byte is readable and writable.
// - Counter bits 12..8 are hidden and come from the high latch.
// - Every reset clears the whole program counter.
// - Writing the low byte loads upper bits from latch bits 4..0.
// - Call or jump takes only latch bits 4..3; the rest from instruction.
// - Eight-entry 13-bit return stack with a pointer software cannot reach.
// - Calls and interrupt vectoring push the program counter.
// - Return, return-with-literal and return-from-interrupt pop into the counter.
// - Pushes and pops leave the high latch untouched.
// - The stack is circular; the ninth push overwrites the first entry.
// - No overflow or underflow indication exists.
// - Accessing the indirect location reaches the data byte the pointer selects.
// - Reading the indirect location through itself returns 00h.
// - Writing the indirect location through itself stores nothing.
// - Indirect address is the bank bit above the 8-bit pointer.
module pcs_core (
	input  wire        CLK,
	input  wire        NRST,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [9:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	input  wire        BOD_DET,
	input  wire        SEQ_INC,
	input  wire        SEQ_JUMP,
	input  wire        SEQ_CALL,
	input  wire [10:0] SEQ_TARGET,
	input  wire        SEQ_IRQ,
	input  wire        SEQ_RET,
	output wire [12:0] PC,
	output wire [5:0]  TRIM_VALUE,
	output wire        INDIRECT_BANK
);

	// Program counter and its high latch
	reg  [12:0] pc_r;
	reg  [12:0] pc_nxt;
	wire [4:0]  pc_high_latch_r;

	// Return stack with its hidden pointer
	reg  [12:0] stk_mem [0:7];
	reg  [2:0]  sp_r;
	reg  [2:0]  sp_nxt;
	wire [2:0]  sp_dec;
	wire        push;
	wire        pop;

	// Indirect addressing state and the data bytes behind it
	wire [7:0]  data_pointer_r;
	wire        indirect_bank_bit_r;
	reg  [7:0]  dmem [0:511];
	wire [8:0]  ind_addr;
	wire        ind_self;

	// Reset-cause flags and oscillator trim
	reg         por_flag_r;
	reg         brownout_flag_r;
	wire [5:0]  trim_value_r;

	// Brown-out detector is asynchronous to the core clock
	wire        bod_sync_r;

	// Bus decode
	wire        bus_req;
	wire        bus_wr;
	wire        bus_rd;
	wire [7:0]  bus_idx;
	wire [7:0]  wdat;
	wire        hit_ind;
	wire        hit_pcl;
	wire        hit_ptr;
	wire        hit_stat;
	wire        hit_lath;
	wire        hit_rc;
	wire        hit_trim;
	reg  [7:0]  rd_byte;

	assign bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign bus_wr   = bus_req & WB_WE_I & WB_SEL_I[0];
	assign bus_rd   = bus_req & ~WB_WE_I;
	assign bus_idx  = WB_ADR_I[`PCS_ADR_W-1:`PCS_IDX_LSB];
	assign wdat     = WB_DAT_I[7:0];
	assign hit_ind  = (bus_idx == `PCS_IDX_IND);
	assign hit_pcl  = (bus_idx == `PCS_IDX_PCL);
	assign hit_ptr  = (bus_idx == `PCS_IDX_PTR);
	assign hit_stat = (bus_idx == `PCS_IDX_STAT);
	assign hit_lath = (bus_idx == `PCS_IDX_LATH);
	assign hit_rc   = (bus_idx == `PCS_IDX_RCAUSE);
	assign hit_trim = (bus_idx == `PCS_IDX_TRIM);

	// Indirect address and the self-reference case
	assign ind_addr = {indirect_bank_bit_r, data_pointer_r};
	assign ind_self = (data_pointer_r == `PCS_IDX_IND);

	// Stack control: when a push and a pop come together from the sequencer, the push wins and the pop is dropped
	assign push   = SEQ_CALL | SEQ_IRQ;
	assign pop    = SEQ_RET & ~push;
	assign sp_dec = sp_r - 3'h1;

	// Two-flop synchroniser on the brown-out input
	pcs_sync #(
		.W (1)
	) u_pcs_sync_bod (
		.clk  (CLK),
		.nrst (NRST),
		.d    (BOD_DET),
		.q    (bod_sync_r)
	);

	// Next program counter; interrupt, call, return and jump outrank a bus write to the low byte, which outranks an increment
	always @* begin
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		if (SEQ_IRQ) begin
			pc_nxt = `PCS_IRQ_VECTOR;
			sp_nxt = sp_r + 3'h1;
		end else if (SEQ_CALL) begin
			pc_nxt = {pc_high_latch_r[4:3], SEQ_TARGET};
			sp_nxt = sp_r + 3'h1;
		end else if (pop) begin
			pc_nxt = stk_mem[sp_dec];
			sp_nxt = sp_dec;
		end else if (SEQ_JUMP) begin
			pc_nxt = {pc_high_latch_r[4:3], SEQ_TARGET};
		end else if (bus_wr && hit_pcl) begin
			// No carry ever moves from the low byte into the latch bits
			pc_nxt = {pc_high_latch_r, wdat};
		end else if (SEQ_INC) begin
			pc_nxt = pc_r + 13'h0001;
		end
	end

	// Counter and stack pointer; brown-out is a reset of these two as well
	always @(posedge CLK) begin
		if (!NRST || bod_sync_r) begin
			pc_r <= 13'h0000;
			sp_r <= 3'h0;
		end else begin
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
		end
	end

	// Stack storage needs no reset; stale entries are what an underflow returns
	always @(posedge CLK) begin
		if (NRST && !bod_sync_r && push) begin
			stk_mem[sp_r] <= pc_r;
		end
	end

	// High latch: only software writes it, never a push or pop
	pcs_swreg #(
		.W   (`PCS_LATH_W),
		.RST (`PCS_LATH_RESET)
	) u_pcs_swreg_lath (
		.clk  (CLK),
		.nrst (NRST),
		.load (bus_wr & hit_lath),
		.d    (wdat[4:0]),
		.q    (pc_high_latch_r)
	);

	// Pointer into the data bytes
	pcs_swreg #(
		.W   (8),
		.RST (`PCS_PTR_RESET)
	) u_pcs_swreg_ptr (
		.clk  (CLK),
		.nrst (NRST),
		.load (bus_wr & hit_ptr),
		.d    (wdat),
		.q    (data_pointer_r)
	);

	// Bank bit lives in the status byte; the other status bits belong to the datapath
	pcs_swreg #(
		.W   (1),
		.RST (`PCS_BANK_RESET)
	) u_pcs_swreg_bank (
		.clk  (CLK),
		.nrst (NRST),
		.load (bus_wr & hit_stat),
		.d    (wdat[`PCS_STAT_BANK_BIT]),
		.q    (indirect_bank_bit_r)
	);

	// Indirect write lands in the pointed byte, except through itself
	always @(posedge CLK) begin
		if (bus_wr && hit_ind && !ind_self) begin
			dmem[ind_addr] <= wdat;
		end
	end

	// Reset-cause flags; the hardware event wins over a software write of one
	always @(posedge CLK) begin
		if (!NRST) begin
			{por_flag_r, brownout_flag_r} <= `PCS_RC_RESET;
		end else begin
			if (bus_wr && hit_rc) begin
				por_flag_r <= wdat[`PCS_RC_POR_BIT];
			end
			if (bod_sync_r) begin
				brownout_flag_r <= 1'b0;
			end else if (bus_wr && hit_rc) begin
				brownout_flag_r <= wdat[`PCS_RC_BOD_BIT];
			end
		end
	end

	// Oscillator trim, centre frequency after reset
	pcs_swreg #(
		.W   (6),
		.RST (`PCS_TRIM_RESET)
	) u_pcs_swreg_trim (
		.clk  (CLK),
		.nrst (NRST),
		.load (bus_wr & hit_trim),
		.d    (wdat[`PCS_TRIM_MSB:`PCS_TRIM_LSB]),
		.q    (trim_value_r)
	);

	// Read multiplexer; unmapped indices read zero
	always @* begin
		rd_byte = 8'h00;
		case (bus_idx)
			`PCS_IDX_IND: begin
				rd_byte = ind_self ? 8'h00 : dmem[ind_addr];
			end
			`PCS_IDX_PCL: begin
				rd_byte = pc_r[7:0];
			end
			`PCS_IDX_PTR: begin
				rd_byte = data_pointer_r;
			end
			`PCS_IDX_STAT: begin
				rd_byte = {indirect_bank_bit_r, 7'h00};
			end
			`PCS_IDX_LATH: begin
				rd_byte = {3'h0, pc_high_latch_r};
			end
			`PCS_IDX_RCAUSE: begin
				rd_byte = {6'h00, por_flag_r, brownout_flag_r};
			end
			`PCS_IDX_TRIM: begin
				rd_byte = {trim_value_r, 2'h0};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Wishbone answer: one cycle after the request, for one cycle
	always @(posedge CLK) begin
		if (!NRST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= bus_req;
			if (bus_rd) begin
				WB_DAT_O <= {24'h000000, rd_byte};
			end
		end
	end

	assign PC            = pc_r;
	assign TRIM_VALUE    = trim_value_r;
	assign INDIRECT_BANK = indirect_bank_bit_r;

endmodule // pcs_core

// Two-flop synchroniser for levels arriving from outside the core clock
module pcs_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         nrst,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg  [W-1:0] meta_r;
	reg  [W-1:0] sync_r;

	// Only the second stage is read, so a metastable first stage never reaches logic
	always @(posedge clk) begin
		if (!nrst) begin
			meta_r <= {W{1'h0}};
			sync_r <= {W{1'h0}};
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;

endmodule // pcs_sync

// Software-loaded register with synchronous reset, shared by latch, pointer, bank bit and trim
module pcs_swreg #(
	parameter         W   = 8,
	parameter [W-1:0] RST = {W{1'h0}}
) (
	input  wire         clk,
	input  wire         nrst,
	input  wire         load,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg  [W-1:0] q_r;

	always @(posedge clk) begin
		if (!nrst) begin
			q_r <= RST;
		end else if (load) begin
			q_r <= d;
		end
	end

	assign q = q_r;

endmodule // pcs_swreg
`default_nettype wire

// ==== dv/pcs_core_properties.sv ====
// Concurrent checks on the ports of the program counter core
`timescale 1ns/10ps
`default_nettype none
module pcs_core_props (
	input wire logic        CLK,
	input wire logic        NRST,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [9:0]  WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        BOD_DET,
	input wire logic        SEQ_CALL,
	input wire logic [10:0] SEQ_TARGET,
	input wire logic        SEQ_IRQ,
	input wire logic        SEQ_RET,
	input wire logic [12:0] PC,
	input wire logic [5:0]  TRIM_VALUE,
	input wire logic        INDIRECT_BANK
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic wr;
	// A write is taken only while the previous answer is gone
	assign wr = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0];
	property p_rst_pc; disable iff (1'h0) !NRST |=> PC == 13'h0000; endproperty
	a_rst_pc: assert property (p_rst_pc) else $error("counter not cleared by reset");
	property p_bod_pc; BOD_DET [*3] |=> PC == 13'h0000; endproperty
	a_bod_pc: assert property (p_bod_pc) else $error("counter not cleared by brown-out");
	property p_call; SEQ_CALL && !SEQ_IRQ |=> PC[10:0] == $past(SEQ_TARGET); endproperty
	a_call: assert property (p_call) else $error("call target not loaded");
	property p_irq; SEQ_IRQ |=> PC == 13'h0004; endproperty
	a_irq: assert property (p_irq) else $error("interrupt vector not loaded");
	sequence s_callret;
		SEQ_CALL ##1 !(SEQ_CALL || SEQ_IRQ || SEQ_RET) ##1 SEQ_RET && !(SEQ_CALL || SEQ_IRQ);
	endsequence
	property p_callret; s_callret |=> PC == $past(PC, 3); endproperty
	a_callret: assert property (p_callret) else $error("return lost the pushed counter");
	property p_bank; wr && WB_ADR_I[9:2] == 8'h03 |=> INDIRECT_BANK == $past(WB_DAT_I[7]); endproperty
	a_bank: assert property (p_bank) else $error("bank bit not taken from status");
	property p_rc_zero; WB_ACK_O && !WB_WE_I && WB_ADR_I[9:2] == 8'h8E |-> WB_DAT_O[7:2] == 6'h00; endproperty
	a_rc_zero: assert property (p_rc_zero) else $error("reset-cause upper bits not zero");
	property p_trim; wr && WB_ADR_I[9:2] == 8'h90 |=> TRIM_VALUE == $past(WB_DAT_I[7:2]); endproperty
	a_trim: assert property (p_trim) else $error("trim field not taken from bits 7 to 2");
	c_callret: cover property (s_callret);
	c_bod: cover property (BOD_DET [*3]);
	c_bank: cover property ($rose(INDIRECT_BANK));
endmodule // pcs_core_props
bind pcs_core pcs_core_props u_pcs_core_props (.*);
`default_nettype wire

// ==== dv/pcs_core_test.sv ====
// Self-checking bench for the program counter core
`timescale 1ns/10ps
`default_nettype none
module pcs_core_test;
	logic        clk, nrst, cyc, stb, we, ack, brownout_flag, inc, jmp, call, irq, ret, bank;
	logic [9:0]  adr;
	logic [31:0] dat, rdat;
	logic [10:0] tgt;
	logic [12:0] pc;
	logic [5:0]  trim;
	logic [7:0]  q;
	logic [3:0]  sel;
	int          error_cnt, checked;
	logic [23:0] rows [7] = '{24'h90FFFC, 24'h908280, 24'h900000, 24'h8E0000, 24'h8EFF03, 24'h015A5A, 24'h55FF00};
	pcs_core u_pcs_core (.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .BOD_DET(brownout_flag), .SEQ_INC(inc),
		.SEQ_JUMP(jmp), .SEQ_CALL(call), .SEQ_TARGET(tgt), .SEQ_IRQ(irq), .SEQ_RET(ret), .PC(pc),
		.TRIM_VALUE(trim), .INDIRECT_BANK(bank));
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task tally_and_finish;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request stays up until ack is seen, then one idle cycle
	task wb(input logic w, input logic [7:0] i, input logic [7:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= 4'h1;
		adr <= {i, 2'h0};
		dat <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'h1);
		q = rdat[7:0];
		cyc <= 0;
		stb <= 0;
		sel <= 4'h0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] i, input logic [7:0] e);
		wb(0, i, 8'h00);
		chk(q, e);
	endtask
	task pulse(input logic [4:0] v, input logic [10:0] t, input logic [12:0] e);
		{irq, call, ret, jmp, inc} <= v;
		tgt <= t;
		@(posedge clk);
		{irq, call, ret, jmp, inc} <= 5'h00;
		@(posedge clk);
		chk(pc, e);
	endtask
	initial begin
		{nrst, cyc, stb, we, brownout_flag, irq, call, ret, jmp, inc} = 0;
		adr = 0;
		sel = 0;
		dat = 0;
		tgt = 0;
		error_cnt = 0;
		checked = 0;
		repeat (8) @(posedge clk);
		nrst <= 1;
		chk(pc, 13'h0000);
		rd(8'h8E, 8'h01);
		rd(8'h90, 8'h80);
		chk(trim, 6'h20);
		foreach (rows[i]) begin
			wb(1, rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		wb(1, 8'h04, 8'h1F);
		wb(1, 8'h01, 8'h00);
		chk(pc, 13'h1F00);
		pulse(5'h01, 11'h000, 13'h1F01);
		pulse(5'h02, 11'h123, 13'h1923);
		pulse(5'h08, 11'h000, 13'h1800);
		pulse(5'h04, 11'h000, 13'h1923);
		wb(1, 8'h01, 8'h00);
		chk(pc, 13'h1F00);
		wb(1, 8'h01, 8'hF0);
		wb(1, 8'h01, 8'h10);
		chk(pc, 13'h1F10);
		wb(1, 8'h04, 8'h00);
		// Nine calls wrap the eight slots, so the oldest entry is lost
		for (int i = 1; i < 10; i++) pulse(5'h08, 11'(i * 16), 13'(i * 16));
		for (int k = 0; k < 9; k++) pulse(5'h04, 11'h000, k < 8 ? 13'((8 - k) * 16) : 13'h0080);
		pulse(5'h10, 11'h000, 13'h0004);
		wb(1, 8'h02, 8'h20);
		wb(1, 8'h00, 8'hA5);
		wb(1, 8'h03, 8'h80);
		chk(bank, 1'h1);
		wb(1, 8'h00, 8'h5A);
		wb(1, 8'h03, 8'h00);
		rd(8'h00, 8'hA5);
		wb(1, 8'h03, 8'h80);
		rd(8'h00, 8'h5A);
		wb(1, 8'h02, 8'h00);
		wb(1, 8'h00, 8'h77);
		rd(8'h00, 8'h00);
		brownout_flag <= 1;
		repeat (4) @(posedge clk);
		brownout_flag <= 0;
		repeat (2) @(posedge clk);
		chk(pc, 13'h0000);
		rd(8'h8E, 8'h02);
		pulse(5'h01, 11'h000, 13'h0001);
		nrst <= 0;
		@(posedge clk);
		nrst <= 1;
		@(posedge clk);
		chk(pc, 13'h0000);
		rd(8'h8E, 8'h01);
		tally_and_finish;
	end
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish;
	end
endmodule // pcs_core_test
`default_nettype wire
